// ### rtl/ipv_ctrl.sv
// Interrupt priority ranking and vector address forming
`timescale 1ns/1ps
//
// Behaviour
// - Higher levels always served before lower levels
// - Same level: smallest vector number wins
// - Entry offset is twice the vector number
// - Chip reset vector 0, watchdog reset 1
// - Core vectors 2 to 5 fixed level 3
// - Debug vectors 6 to 10 programmable 1-3
// - Peripheral field: 00 off, else level 0-2
// - Priority register 3 holds eight 2-bit fields
// - Address is base 14 bits plus 7 low
module ipv_ctrl (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire ipv_pkg::ipv_src_s src,
    input wire logic [1:0] core_mask,
    input wire logic irq_ack,
    input wire logic wdog_reset_cause,
    output ipv_pkg::ipv_core_s core_out,
    output logic [20:0] reset_addr
);
    import ipv_pkg::*;

    logic [15:0] prio3_reg;
    logic [9:0] dbg_prio_reg;
    logic [13:0] vbase_reg;
    ipv_state_e state_reg;
    logic [7:0] per_en;
    logic [1:0] per_lvl [IPV_NPER];
    logic [4:0] dbg_en;
    logic [1:0] dbg_lvl [IPV_NDBG];
    logic [IPV_NVEC-1:0] pend;
    logic [1:0] lvl [IPV_NVEC];
    logic win_found;
    logic [5:0] win_vec;
    logic [1:0] win_lvl;
    logic win_ok;
    logic viol_lvl;
    logic viol_vec;

    // Peripheral fields: 00 off, 01..11 give levels 0..2, never 3
    for (genvar i = 0; i < IPV_NPER; i++) begin : g_per
        assign per_en[i] = prio3_reg[2*i+1 -: 2] != 2'h0;
        assign per_lvl[i] = prio3_reg[2*i+1 -: 2] - 2'h1;
    end

    // Debug fields: 00 off, 01..11 give levels 1..3
    for (genvar i = 0; i < IPV_NDBG; i++) begin : g_dbg
        assign dbg_en[i] = dbg_prio_reg[2*i+1 -: 2] != 2'h0;
        assign dbg_lvl[i] = dbg_prio_reg[2*i+1 -: 2];
    end

    // Per vector: pending request and level, zero where no source sits
    for (genvar v = 0; v < IPV_NVEC; v++) begin : g_vec
        if (v >= IPV_VEC_CORE && v < IPV_VEC_DBG) begin : g_core
            assign pend[v] = src.core[v - IPV_VEC_CORE];
            assign lvl[v] = IPV_LVL_TOP;
        end else if (v >= IPV_VEC_DBG && v < IPV_VEC_DBG + IPV_NDBG) begin : g_dbgv
            assign pend[v] = src.dbg[v - IPV_VEC_DBG] && dbg_en[v - IPV_VEC_DBG];
            assign lvl[v] = dbg_lvl[v - IPV_VEC_DBG];
        end else if (v >= IPV_VEC_SW && v < IPV_VEC_SW + 3) begin : g_sw
            assign pend[v] = src.sw[v - IPV_VEC_SW];
            assign lvl[v] = 2'(int'(IPV_VEC_SW) + 2 - v);
        end else if (v >= IPV_VEC_PER && v < IPV_VEC_PER + IPV_NPER) begin : g_perv
            assign pend[v] = src.per[v - IPV_VEC_PER] && per_en[v - IPV_VEC_PER];
            assign lvl[v] = per_lvl[v - IPV_VEC_PER];
        end else begin : g_none
            assign pend[v] = 1'b0;
            assign lvl[v] = 2'h0;
        end
    end

    // Ascending scan, replace only on a strictly higher level
    always_comb begin
        win_found = 1'b0;
        win_vec = 6'h00;
        win_lvl = 2'h0;
        for (int v = 0; v < IPV_NVEC; v++) begin
            if (pend[v] && (!win_found || lvl[v] > win_lvl)) begin
                win_found = 1'b1;
                win_vec = 6'(v);
                win_lvl = lvl[v];
            end
        end
    end

    assign win_ok = win_found && win_lvl >= core_mask;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prio3_reg <= IPV_PRIO3_RST;
            dbg_prio_reg <= IPV_DBG_RST;
            vbase_reg <= IPV_VBASE_RST;
        end else if (reg_wr) begin
            if (reg_addr == IPV_OFS_PRIO3) begin
                prio3_reg <= reg_wdata;
            end else if (reg_addr == IPV_OFS_DBG_PRIO) begin
                dbg_prio_reg <= reg_wdata[9:0];
            end else if (reg_addr == IPV_OFS_VBASE) begin
                vbase_reg <= reg_wdata[13:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == IPV_OFS_PRIO3) begin
            reg_rdata <= prio3_reg;
        end else if (reg_addr == IPV_OFS_DBG_PRIO) begin
            reg_rdata <= {6'h00, dbg_prio_reg};
        end else if (reg_addr == IPV_OFS_VBASE) begin
            reg_rdata <= {2'h0, vbase_reg};
        end else if (reg_addr == IPV_OFS_STATUS) begin
            reg_rdata <= {7'h00, core_out.req, core_out.level, core_out.vec};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Winner is latched and held until the core acknowledges it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= IPV_IDLE;
            core_out <= '0;
        end else begin
            case (state_reg)
                IPV_IDLE: begin
                    if (win_ok) begin
                        state_reg <= IPV_PRESENT;
                        core_out.req <= 1'b1;
                        core_out.level <= win_lvl;
                        core_out.vec <= win_vec;
                        core_out.addr <= {vbase_reg, win_vec, 1'b0};
                    end
                end
                IPV_PRESENT: begin
                    if (irq_ack) begin
                        state_reg <= IPV_IDLE;
                        core_out.req <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= IPV_IDLE;
                    core_out.req <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reset_addr <= 21'h000000;
        end else begin
            reset_addr <= {vbase_reg, wdog_reset_cause ? IPV_VEC_WDOG : IPV_VEC_RESET, 1'b0};
        end
    end

    // Helper: any pending source that should have beaten the winner
    always_comb begin
        viol_lvl = 1'b0;
        viol_vec = 1'b0;
        for (int v = 0; v < IPV_NVEC; v++) begin
            if (pend[v] && lvl[v] > win_lvl) begin
                viol_lvl = 1'b1;
            end
            if (pend[v] && lvl[v] == win_lvl && 6'(v) < win_vec) begin
                viol_vec = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_level_first: assert property (
        win_found
        |-> !viol_lvl)
        else $error("higher level pending source lost ranking");
    a_low_vector: assert property (
        win_found
        |-> !viol_vec)
        else $error("lower vector at same level lost ranking");
    a_win_pending: assert property (
        win_found
        |-> pend[win_vec])
        else $error("winner is not a pending source");
    a_level_match: assert property (
        $rose(core_out.req)
        |-> core_out.level == $past(win_lvl))
        else $error("presented level differs from winner level");
    a_entry_offset: assert property (
        core_out.req
        |-> core_out.addr[6:0] == {core_out.vec, 1'b0})
        else $error("entry offset not twice vector number");
    a_addr_even: assert property (
        core_out.req
        |-> core_out.addr[0] == 1'b0)
        else $error("vector address not on an entry boundary");
    a_reset_entry: assert property (
        1'b1
        |=> reset_addr[6:0] == ($past(wdog_reset_cause) ? 7'h02 : 7'h00))
        else $error("reset entry not vector 0 or 1");
    a_reset_base: assert property (
        1'b1
        |=> reset_addr[20:7] == $past(vbase_reg))
        else $error("reset entry upper bits not from base");
    a_vec_reserved: assert property (
        core_out.req
        |-> core_out.vec >= IPV_VEC_CORE)
        else $error("reset entry presented as interrupt");
    a_core_fixed: assert property (
        $rose(core_out.req) && core_out.vec inside {[2:5]}
        |-> core_out.level == 2'h3)
        else $error("core source not at level 3");
    a_debug_level: assert property (
        $rose(core_out.req) && core_out.vec inside {[6:10]}
        |-> core_out.level != 2'h0)
        else $error("debug source at level 0");
    a_per_level: assert property (
        $rose(core_out.req) && core_out.vec >= IPV_VEC_PER
        |-> core_out.level != 2'h3 && (($past(prio3_reg) >> {core_out.vec - IPV_VEC_PER, 1'b0}) & 16'h0003) != 16'h0000)
        else $error("peripheral source disabled or at level 3");
    a_base_bits: assert property (
        $rose(core_out.req)
        |-> core_out.addr[20:7] == $past(vbase_reg))
        else $error("vector address upper bits not from base");
    a_mask_gate: assert property (
        $rose(core_out.req)
        |-> $past(win_lvl) >= $past(core_mask))
        else $error("request presented below core mask");
    a_hold_ack: assert property (
        core_out.req && !irq_ack
        |=> core_out.req && $stable(core_out.addr))
        else $error("request dropped or changed before ack");
    a_ack_release: assert property (
        core_out.req && irq_ack
        |=> !core_out.req)
        else $error("request still raised after ack");
    a_present_win: assert property (
        state_reg == IPV_IDLE && win_ok
        |=> core_out.req && core_out.vec == $past(win_vec))
        else $error("eligible winner not presented");
    a_no_spurious: assert property (
        state_reg == IPV_IDLE && !win_ok
        |=> !core_out.req)
        else $error("request raised with no eligible winner");
    a_state_onehot: assert property (
        1'b1
        |-> $onehot(state_reg))
        else $error("presenting state not one-hot");

    a_prio3_write: assert property (
        reg_wr && reg_addr == IPV_OFS_PRIO3
        |=> prio3_reg == $past(reg_wdata))
        else $error("priority register 3 write lost");
    a_prio3_read: assert property (
        reg_rd && reg_addr == IPV_OFS_PRIO3
        |=> reg_rdata == $past(prio3_reg))
        else $error("priority register 3 read wrong");
    a_rdata_idle: assert property (
        !reg_rd
        |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_dbg_write: assert property (
        reg_wr && reg_addr == IPV_OFS_DBG_PRIO
        |=> dbg_prio_reg == $past(reg_wdata[9:0]))
        else $error("debug priority write lost");
    a_dbg_read: assert property (
        reg_rd && reg_addr == IPV_OFS_DBG_PRIO
        |=> reg_rdata == {6'h00, $past(dbg_prio_reg)})
        else $error("debug priority read wrong");
    a_vbase_write: assert property (
        reg_wr && reg_addr == IPV_OFS_VBASE
        |=> vbase_reg == $past(reg_wdata[13:0]))
        else $error("vector base write lost");
    a_vbase_read: assert property (
        reg_rd && reg_addr == IPV_OFS_VBASE
        |=> reg_rdata == {2'h0, $past(vbase_reg)})
        else $error("vector base read wrong");
    a_status_read: assert property (
        reg_rd && reg_addr == IPV_OFS_STATUS
        |=> reg_rdata == {7'h00, $past(core_out.req), $past(core_out.level), $past(core_out.vec)})
        else $error("status read wrong");

    c_core_win: cover property ($rose(core_out.req) && core_out.vec == IPV_VEC_CORE);
    c_per_win: cover property ($rose(core_out.req) && core_out.vec >= IPV_VEC_PER);
    c_ack_cycle: cover property (core_out.req ##1 irq_ack ##1 !core_out.req);
    c_masked: cover property (win_found && !win_ok [*3]);
    c_wdog_entry: cover property ($rose(reset_addr[1]));
endmodule // ipv_ctrl

// ### rtl/ipv_pkg.sv
// Constants, states and bundles of the interrupt priority vectoring block
package ipv_pkg;
    localparam logic [3:0] IPV_OFS_DBG_PRIO = 4'h0;
    localparam logic [3:0] IPV_OFS_PRIO3 = 4'h3;
    localparam logic [3:0] IPV_OFS_VBASE = 4'h4;
    localparam logic [3:0] IPV_OFS_STATUS = 4'h5;
    localparam logic [15:0] IPV_PRIO3_RST = 16'h0000;
    localparam logic [9:0] IPV_DBG_RST = 10'h000;
    localparam logic [13:0] IPV_VBASE_RST = 14'h0000;
    localparam int IPV_NVEC = 64;
    localparam int IPV_NPER = 8;
    localparam int IPV_NDBG = 5;
    localparam logic [5:0] IPV_VEC_RESET = 6'h00;
    localparam logic [5:0] IPV_VEC_WDOG = 6'h01;
    localparam logic [5:0] IPV_VEC_CORE = 6'h02;
    localparam logic [5:0] IPV_VEC_DBG = 6'h06;
    localparam logic [5:0] IPV_VEC_SW = 6'h0b;
    localparam logic [5:0] IPV_VEC_PER = 6'h28;
    localparam logic [1:0] IPV_LVL_TOP = 2'h3;
    typedef enum logic [1:0] {IPV_IDLE = 2'b01, IPV_PRESENT = 2'b10} ipv_state_e;
    // Level requests: core 2..5, debug 6..10, software 11..13, peripherals
    typedef struct packed {
        logic [3:0] core;
        logic [4:0] dbg;
        logic [2:0] sw;
        logic [7:0] per;
    } ipv_src_s;
    typedef struct packed {
        logic req;
        logic [1:0] level;
        logic [5:0] vec;
        logic [20:0] addr;
    } ipv_core_s;
endpackage

// ### test/ipv_core_model.sv
// Core side model that acknowledges a presented interrupt after a set delay
`timescale 1ns/1ps
module ipv_core_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire ipv_pkg::ipv_core_s core_out,
    input wire logic [3:0] ack_delay,
    output logic irq_ack
);
    import ipv_pkg::*;
    logic [3:0] wait_reg;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg <= 4'h0;
            irq_ack <= 1'b0;
        end else if (core_out.req && !irq_ack) begin
            wait_reg <= wait_reg + 4'h1;
            irq_ack <= (wait_reg >= ack_delay);
        end else begin
            wait_reg <= 4'h0;
            irq_ack <= 1'b0;
        end
    end
endmodule // ipv_core_model

// ### test/tb.sv
// Register and vectoring sequences for the interrupt priority block
`timescale 1ns/1ps
module tb;
    import ipv_pkg::*;
    logic clk_sys;
    logic rst_b;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    ipv_src_s src;
    logic [1:0] core_mask;
    logic irq_ack;
    logic wdog_reset_cause;
    ipv_core_s core_out;
    logic [20:0] reset_addr;
    logic [3:0] ack_delay;
    logic [13:0] vb = 14'h2a5f;
    int errors = 0;
    int checks = 0;
    ipv_ctrl ipv_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src(src), .core_mask(core_mask), .irq_ack(irq_ack),
        .wdog_reset_cause(wdog_reset_cause), .core_out(core_out), .reset_addr(reset_addr));
    ipv_core_model ipv_core_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .core_out(core_out), .ack_delay(ack_delay), .irq_ack(irq_ack));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk("reg_rdata", {5'h00, reg_rdata}, {5'h00, e});
    endtask
    task automatic await(input logic lvl);
        int n;
        n = 0;
        while (core_out.req !== lvl) begin
            @(negedge clk_sys);
            n++;
            if (n > 40) begin
                errors++;
                end_sim();
            end
        end
    endtask
    task automatic serve(input logic [5:0] v, input logic [1:0] l, input int b);
        @(posedge clk_sys);
        ack_delay <= {1'b0, v[2:0]};
        await(1'b1);
        chk("vec", {15'h0000, core_out.vec}, {15'h0000, v});
        chk("level", {19'h00000, core_out.level}, {19'h00000, l});
        chk("addr", core_out.addr, {vb, v, 1'b0});
        @(posedge clk_sys);
        src <= src & ~(20'h00001 << b);
        await(1'b0);
    endtask
    task automatic quiet();
        repeat (8) begin
            @(negedge clk_sys);
            chk("req", {20'h00000, core_out.req}, 21'h000000);
        end
    endtask
    initial begin
        rst_b = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        src = '0;
        core_mask = 2'h0;
        wdog_reset_cause = 1'b0;
        ack_delay = 4'h0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(IPV_OFS_PRIO3, 16'h0000);
        rdc(IPV_OFS_DBG_PRIO, 16'h0000);
        chk("reset_addr", reset_addr, 21'h000000);
        wr(IPV_OFS_PRIO3, 16'hc081);
        wr(IPV_OFS_DBG_PRIO, 16'hfc0d);
        wr(IPV_OFS_VBASE, 16'hea5f);
        wr(4'h7, 16'hffff);
        rdc(IPV_OFS_PRIO3, 16'hc081);
        rdc(IPV_OFS_DBG_PRIO, 16'h000d);
        rdc(IPV_OFS_VBASE, {2'b00, vb});
        rdc(4'h7, 16'h0000);
        @(posedge clk_sys);
        wdog_reset_cause <= 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("reset_addr", reset_addr, {vb, 7'h02});
        @(posedge clk_sys);
        core_mask <= 2'h3;
        src <= 20'h23f8b;
        serve(6'h03, 2'h3, 17);
        serve(6'h07, 2'h3, 12);
        quiet();
        rdc(IPV_OFS_STATUS, 16'h00c7);
        @(posedge clk_sys);
        core_mask <= 2'h0;
        serve(6'h0b, 2'h2, 8);
        serve(6'h2f, 2'h2, 7);
        serve(6'h06, 2'h1, 11);
        serve(6'h0c, 2'h1, 9);
        serve(6'h2b, 2'h1, 3);
        serve(6'h0d, 2'h0, 10);
        serve(6'h28, 2'h0, 0);
        quiet();
        rdc(IPV_OFS_STATUS, 16'h0028);
        end_sim();
    end
endmodule // tb
